// [hdl/mrp_pkg.sv]
// Shared constants, types and register map of the traffic mirror probe block.
package mrp_pkg;
	localparam int NPROBE = 3;
	localparam int NPORT  = 12;
	localparam int NCPU   = 2;
	localparam int NCV    = 4;
	localparam int PW     = 4;
	localparam int VIDW   = 12;
	localparam int PIW    = 2;
	localparam int AW     = 8;
	localparam int DW     = 32;
	// Per-probe register block: probe index in address bits 6:5, register in 4:0.
	localparam int PRB_LSB = 5;
	localparam logic [4:0] REG_CFG  = 5'h00;
	localparam logic [4:0] REG_PORT = 5'h04;
	localparam logic [4:0] REG_CPU  = 5'h08;
	localparam logic [4:0] REG_RXCV = 5'h0C;
	localparam logic [4:0] REG_DEST = 5'h10;
	localparam logic [AW-1:0] REG_CTRL   = 8'h60;
	localparam logic [AW-1:0] REG_FRAMES = 8'h64;
	localparam logic [AW-1:0] REG_COPIES = 8'h68;
	// Field positions in the probe configuration word.
	localparam int CFG_DIR_LSB  = 0;
	localparam int CFG_STA_LSB  = 2;
	localparam int CFG_VLAN_LSB = 4;
	localparam int CFG_PHYS_BIT = 6;
	localparam int CFG_VID_LSB  = 16;
	// Field positions in the global control word.
	localparam int CTL_FLOOD_BIT = 0;
	localparam int CTL_RXTAG_BIT = 1;
	localparam int CTL_TXTAG_BIT = 2;
	localparam int CTL_TXP_LSB   = 8;
	localparam int DIR_TX_BIT = 0;
	localparam int DIR_RX_BIT = 1;
	localparam int STA_DST_BIT = 0;
	localparam int STA_SRC_BIT = 1;
	localparam logic [1:0] VLAN_SEL_FLAG = 2'h1;
	localparam logic [1:0] VLAN_SEL_VID  = 2'h2;
	localparam logic [DW-1:0] RD_ZERO = 32'h0000_0000;
	typedef struct packed {
		logic [PW-1:0]    rx_phys_port;
		logic [PW-1:0]    rx_masq_port;
		logic [NCV-1:0]   rx_cpu_vd;
		logic [NPORT-1:0] tx_port_mask;
		logic [NCPU-1:0]  cpu_dest_mask;
		logic [VIDW-1:0]  vid;
		logic             vlan_entry_copy_flag;
		logic             src_copy_flag;
		logic             dst_copy_flag;
		logic             flooded;
		logic             rule_hit;
		logic [PIW-1:0]   rule_probe;
	} mrp_frame_s;
	typedef struct packed {
		logic [1:0]       dir;
		logic [1:0]       station_filter_sel;
		logic [1:0]       vlan_filter_sel;
		logic             rx_physical_port_sel;
		logic [VIDW-1:0]  filter_vlan_id;
		logic [NPORT-1:0] port_mask;
		logic [NCPU-1:0]  cpu_set;
		logic [NCV-1:0]   rx_cpu_virtual_port_mask;
		logic [PW-1:0]    copy_destination_port;
	} mrp_probe_cfg_s;
	typedef struct packed {
		logic           copy;
		logic [PIW-1:0] probe;
		logic [PW-1:0]  dest;
		logic           is_rx;
		logic [PW-1:0]  rewrite_port;
		logic           add_qtag;
	} mrp_copy_s;
endpackage : mrp_pkg

// [hdl/mrp_frame_if.sv]
// Frame descriptor carrier between the top and the probe matchers.
`timescale 1ns/1ps
interface mrp_frame_if import mrp_pkg::*;;
	mrp_frame_s frame;
	logic       valid;
	modport drv (output frame, output valid);
	modport mon (input frame, input valid);
endinterface : mrp_frame_if

// [hdl/mrp_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides and registered flags.
`timescale 1ns/1ps
module mrp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	localparam int AWD = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AWD-1:0]   wp_r, rp_r;
	logic [AWD:0]     cnt_r, cnt_nxt;
	wire              push = wr_valid_i && wr_ready_o;
	wire              pop  = rd_valid_o && rd_ready_i;
	// Occupancy follows pushes and pops; flags come from the next count.
	assign cnt_nxt   = cnt_r + (AWD+1)'(push) - (AWD+1)'(pop);
	assign rd_data_o = mem_r[rp_r];
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			wr_ready_o <= 1'b0;
			rd_valid_o <= 1'b0;
		end else begin
			wp_r <= push ? AWD'(wp_r + 1'b1) : wp_r;
			rp_r <= pop ? AWD'(rp_r + 1'b1) : rp_r;
			cnt_r <= cnt_nxt;
			wr_ready_o <= (cnt_nxt != (AWD+1)'(DEPTH));
			rd_valid_o <= (cnt_nxt != '0);
		end
	end
	// Storage writes need no reset.
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_r[wp_r] <= wr_data_i;
		end
	end
endmodule : mrp_fifo

// [hdl/mrp_probe_match.sv]
// One mirror probe: filters a frame descriptor against its configuration.
`timescale 1ns/1ps
module mrp_probe_match import mrp_pkg::*; #(
	parameter int IDX = 0
) (
	mrp_frame_if.mon       fr,
	input  wire mrp_probe_cfg_s cfg_i,
	input  wire logic      flooded_copy_enable_i,
	output logic           hit_o,
	output logic           is_rx_o
);
	logic [PW-1:0] rx_port;
	logic          port_hit, rx_dir, tx_dir, vlan_ok, sta_ok, rule_own;
	assign rx_port  = cfg_i.rx_physical_port_sel ? fr.frame.rx_phys_port
	                                               : fr.frame.rx_masq_port;
	assign port_hit = (rx_port < PW'(NPORT)) && cfg_i.port_mask[rx_port];
	assign rx_dir   = cfg_i.dir[DIR_RX_BIT] &&
	                  (port_hit || |(fr.frame.rx_cpu_vd & cfg_i.rx_cpu_virtual_port_mask));
	assign tx_dir   = cfg_i.dir[DIR_TX_BIT] &&
	                  (|(fr.frame.tx_port_mask & cfg_i.port_mask) ||
	                   |(fr.frame.cpu_dest_mask & cfg_i.cpu_set));
	assign vlan_ok  = (cfg_i.vlan_filter_sel == VLAN_SEL_VID)  ? (fr.frame.vid == cfg_i.filter_vlan_id) :
	                  (cfg_i.vlan_filter_sel == VLAN_SEL_FLAG) ? fr.frame.vlan_entry_copy_flag : 1'b1;
	assign sta_ok   = (!cfg_i.station_filter_sel[STA_SRC_BIT] || fr.frame.src_copy_flag) &&
	                  (!cfg_i.station_filter_sel[STA_DST_BIT] || fr.frame.dst_copy_flag ||
	                   (fr.frame.flooded && flooded_copy_enable_i));
	assign rule_own = fr.frame.rule_hit && (fr.frame.rule_probe == PIW'(IDX));
	// frames whose rule names this probe see only direction, else all filters ANDed.
	assign hit_o    = fr.valid && (rule_own ? (|cfg_i.dir) : ((rx_dir || tx_dir) && vlan_ok && sta_ok));
	assign is_rx_o  = rule_own ? cfg_i.dir[DIR_RX_BIT] : rx_dir;
endmodule : mrp_probe_match

// [hdl/mrp_mirror_top.sv]
// Mirror probe top: registers, three probes, winner select and output FIFO.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module mrp_mirror_top import mrp_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic           sys_clk_i,
	input  wire logic           rst_n_i,
	input  wire logic [AW-1:0]  addr_i,
	input  wire logic [DW-1:0]  wr_data_i,
	input  wire logic           wr_i,
	input  wire logic           rd_i,
	output logic      [DW-1:0]  rd_data_o,
	input  wire logic           in_valid_i,
	output logic                in_ready_o,
	input  wire mrp_frame_s     in_frame_i,
	output logic                out_valid_o,
	input  wire logic           out_ready_i,
	output mrp_frame_s          out_frame_o,
	output mrp_copy_s           out_copy_o
);
	localparam int FW = $bits(mrp_frame_s) + $bits(mrp_copy_s);

	mrp_probe_cfg_s   cfg_r [NPROBE];
	logic             flood_en_r, rx_tag_r, tx_tag_r;
	logic [PW-1:0]    tx_ref_port_r;
	logic [15:0]      frames_r, copies_r;
	logic [NPROBE-1:0] hit, is_rx;
	logic [PIW-1:0]   win_idx;
	logic             any_hit, accept;
	mrp_copy_s        copy_nxt;
	logic [FW-1:0]    fifo_rd;
	logic             fifo_vld, fifo_pop;
	logic [DW-1:0]    rd_data_nxt;

	// Register address decode.
	wire [PIW-1:0] prb_sel   = addr_i[PRB_LSB +: PIW];
	wire [4:0]     prb_reg   = addr_i[4:0];
	wire           prb_space = (addr_i < REG_CTRL) && (prb_sel < PIW'(NPROBE));
	wire           wr_ctrl   = wr_i && (addr_i == REG_CTRL);

	// Frame descriptor carried to all probes.
	mrp_frame_if fr_if ();
	assign fr_if.frame = in_frame_i;
	assign fr_if.valid = in_valid_i;

	// Per-probe configuration and matcher.
	genvar g;
	generate
		for (g = 0; g < NPROBE; g++) begin : g_probe
			wire wr_me = wr_i && prb_space && (prb_sel == PIW'(g));
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					cfg_r[g] <= '0;
				end else if (wr_me) begin
					unique case (prb_reg)
						REG_CFG: begin
							cfg_r[g].dir <= wr_data_i[CFG_DIR_LSB +: 2];
							cfg_r[g].station_filter_sel <= wr_data_i[CFG_STA_LSB +: 2];
							cfg_r[g].vlan_filter_sel <= wr_data_i[CFG_VLAN_LSB +: 2];
							cfg_r[g].rx_physical_port_sel <= wr_data_i[CFG_PHYS_BIT];
							cfg_r[g].filter_vlan_id <= wr_data_i[CFG_VID_LSB +: VIDW];
						end
						REG_PORT: cfg_r[g].port_mask <= wr_data_i[NPORT-1:0];
						REG_CPU:  cfg_r[g].cpu_set <= wr_data_i[NCPU-1:0];
						REG_RXCV: cfg_r[g].rx_cpu_virtual_port_mask <= wr_data_i[NCV-1:0];
						REG_DEST: cfg_r[g].copy_destination_port <= wr_data_i[PW-1:0];
						default: ;
					endcase
				end
			end
			mrp_probe_match #(.IDX(g)) u_match (
				.fr                    (fr_if.mon),
				.cfg_i                 (cfg_r[g]),
				.flooded_copy_enable_i (flood_en_r),
				.hit_o                 (hit[g]),
				.is_rx_o               (is_rx[g])
			);
		end
	endgenerate

	// Global control register.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			flood_en_r <= 1'b0;
			rx_tag_r <= 1'b0;
			tx_tag_r <= 1'b0;
			tx_ref_port_r <= '0;
		end else if (wr_ctrl) begin
			flood_en_r <= wr_data_i[CTL_FLOOD_BIT];
			rx_tag_r <= wr_data_i[CTL_RXTAG_BIT];
			tx_tag_r <= wr_data_i[CTL_TXTAG_BIT];
			tx_ref_port_r <= wr_data_i[CTL_TXP_LSB +: PW];
		end
	end

	always_comb begin
		win_idx = '0;
		for (int i = 0; i < NPROBE; i++) begin
			if (hit[i]) begin
				win_idx = PIW'(i);
			end
		end
	end
	assign any_hit = |hit;
	assign accept  = in_valid_i && in_ready_o;

	assign copy_nxt.copy         = any_hit;
	assign copy_nxt.probe        = win_idx;
	assign copy_nxt.dest         = cfg_r[win_idx].copy_destination_port;
	assign copy_nxt.is_rx        = is_rx[win_idx];
	assign copy_nxt.rewrite_port = is_rx[win_idx] ? cfg_r[win_idx].copy_destination_port
	                                               : tx_ref_port_r;
	assign copy_nxt.add_qtag     = is_rx[win_idx] ? rx_tag_r : tx_tag_r;

	// original descriptor travels unchanged beside the copy.
	mrp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.wr_valid_i (in_valid_i),
		.wr_ready_o (in_ready_o),
		.wr_data_i  ({in_frame_i, copy_nxt}),
		.rd_valid_o (fifo_vld),
		.rd_ready_i (fifo_pop),
		.rd_data_o  (fifo_rd)
	);

	// Output stage refills whenever empty or drained.
	assign fifo_pop = fifo_vld && (!out_valid_o || out_ready_i);
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			out_valid_o <= 1'b0;
			out_frame_o <= '0;
			out_copy_o <= '0;
		end else if (!out_valid_o || out_ready_i) begin
			out_valid_o <= fifo_vld;
			out_frame_o <= fifo_rd[FW-1 -: $bits(mrp_frame_s)];
			out_copy_o <= fifo_rd[$bits(mrp_copy_s)-1:0];
		end
	end

	// Statistics of accepted frames and produced copies.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			frames_r <= '0;
			copies_r <= '0;
		end else if (accept) begin
			frames_r <= frames_r + 16'h0001;
			copies_r <= copies_r + 16'(any_hit);
		end
	end

	// Read mux; unmapped addresses read zero.
	wire mrp_probe_cfg_s rc = cfg_r[prb_sel];
	assign rd_data_nxt =
		(prb_space && prb_reg == REG_CFG)  ? DW'({rc.filter_vlan_id, 9'h000,
		                                         rc.rx_physical_port_sel, rc.vlan_filter_sel,
		                                         rc.station_filter_sel, rc.dir}) :
		(prb_space && prb_reg == REG_PORT) ? DW'(rc.port_mask) :
		(prb_space && prb_reg == REG_CPU)  ? DW'(rc.cpu_set) :
		(prb_space && prb_reg == REG_RXCV) ? DW'(rc.rx_cpu_virtual_port_mask) :
		(prb_space && prb_reg == REG_DEST) ? DW'(rc.copy_destination_port) :
		(addr_i == REG_CTRL)   ? DW'({tx_ref_port_r, 5'h00, tx_tag_r, rx_tag_r, flood_en_r}) :
		(addr_i == REG_FRAMES) ? DW'(frames_r) :
		(addr_i == REG_COPIES) ? DW'(copies_r) : RD_ZERO;

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_data_o <= RD_ZERO;
		end else begin
			rd_data_o <= rd_i ? rd_data_nxt : RD_ZERO;
		end
	end

	// Checks on the probe selection and the copy stream.
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Winner is the top matching probe.
	winner_top_a: assert property (hit[NPROBE-1] |-> win_idx == PIW'(NPROBE-1))
		else $error("winner is not the highest matching probe");
	// A selected probe really matched.
	winner_hit_a: assert property (any_hit |-> hit[win_idx])
		else $error("winner probe did not match");
	// No higher probe than the winner matched.
	winner_max_a: assert property (any_hit |-> (hit >> (win_idx + 1'b1)) == '0)
		else $error("higher probe matched but lost");
	// Copy counter steps on accepted matching frames.
	copy_count_a: assert property (accept && any_hit |=> copies_r == $past(copies_r) + 16'h0001)
		else $error("copy counter did not advance");
	// Each copy goes to its probe destination.
	copy_dest_a: assert property (any_hit |-> copy_nxt.dest == cfg_r[win_idx].copy_destination_port)
		else $error("copy destination differs from probe setting");
	// Tx copies use the rewrite reference port.
	tx_rewrite_a: assert property (any_hit && !is_rx[win_idx] |-> copy_nxt.rewrite_port == tx_ref_port_r)
		else $error("tx copy not edited as reference port");
	// Rx copies tagged only when enabled.
	rx_tag_a: assert property (any_hit && is_rx[win_idx] |-> copy_nxt.add_qtag == rx_tag_r)
		else $error("rx copy tag choice wrong");
	// Disabled probe 0 never matches.
	probe_off_a: assert property (cfg_r[0].dir == 2'b00 |-> !hit[0])
		else $error("probe with no direction matched");
	// Output descriptor holds while stalled.
	out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_frame_o))
		else $error("original frame changed while stalled");
	// Read data vanish after one cycle.
	rd_pulse_a: assert property (!rd_i |=> rd_data_o == RD_ZERO)
		else $error("read data stood too long");

	multi_hit_c: cover property (hit[0] && hit[NPROBE-1]);
	rule_hit_c: cover property (in_valid_i && in_frame_i.rule_hit && any_hit);
	fifo_full_c: cover property (in_valid_i && !in_ready_o);
	tx_copy_c: cover property (accept && any_hit && !is_rx[win_idx]);
endmodule : mrp_mirror_top

// [tb/mrp_sink_model.sv]
// Downstream forwarding model that takes output descriptors with random or forced stalls.
`timescale 1ns/1ps
module mrp_sink_model #(
	parameter int SEED = 8304
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic hold_i,
	output logic      ready_o
);
	int seed = SEED;
	// Ready drops at random so the output stage must hold its word under stall.
	always @(posedge sys_clk_i) begin
		if (!rst_n_i || hold_i) begin
			ready_o <= 1'b0;
		end else begin
			ready_o <= ($random(seed) & 3) != 0;
		end
	end
endmodule : mrp_sink_model

// [tb/test_switch_traffic_mirror_probes.sv]
// Self-checking bench of the mirror probe top against a behavioural probe model.
`timescale 1ns/1ps
module test_switch_traffic_mirror_probes import mrp_pkg::*;;
	logic            sys_clk_i, rst_n_i, wr_i, rd_i, in_valid_i, hold, ok;
	logic [AW-1:0]   addr_i;
	logic [DW-1:0]   wr_data_i, rd_data_o, d;
	logic            in_ready_o, out_valid_o, out_ready_i;
	mrp_frame_s      in_frame_i, out_frame_o, f;
	mrp_copy_s       out_copy_o, e;
	mrp_frame_s      fq[$];
	mrp_copy_s       cq[$];
	int              seed = 8303, miscompares = 0, checks_done = 0, taken = 0, copies = 0, t0;
	logic [1:0]      dir[3], sta[3], vl[3], cpu[3];
	logic            phys[3], flood, rxtag, txtag;
	logic [11:0]     vid[3], pmask[3];
	logic [3:0]      rxcv[3], dest[3], txp;

	mrp_mirror_top mrp_mirror_top_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
		.in_frame_i(in_frame_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
		.out_frame_o(out_frame_o), .out_copy_o(out_copy_o));
	mrp_sink_model mrp_sink_model_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.hold_i(hold), .ready_o(out_ready_i));

	// Free-running 125 MHz clock.
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	task check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		if (miscompares == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= v;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		v = rd_data_o;
	endtask : rd

	function automatic logic [DW-1:0] cfg_word(input int p);
		return DW'({vid[p], 9'h000, phys[p], vl[p], sta[p], dir[p]});
	endfunction : cfg_word

	function automatic mrp_frame_s rnd_frame();
		logic [63:0] v;
		mrp_frame_s  r;
		v = {$random(seed), $random(seed)};
		r = v[$bits(mrp_frame_s)-1:0];
		if (r.rule_probe == 2'h3) r.rule_probe = 2'h2;
		return r;
	endfunction : rnd_frame

	// Probe model: the highest matching probe gives the single copy.
	function automatic mrp_copy_s expect_copy(input mrp_frame_s x);
		mrp_copy_s  c;
		logic       rxm, txm, hit;
		logic [3:0] rp;
		c = '0;
		for (int p = 0; p < 3; p++) begin
			rp = phys[p] ? x.rx_phys_port : x.rx_masq_port;
			rxm = dir[p][1] && ((rp < 4'hC && pmask[p][rp]) || |(x.rx_cpu_vd & rxcv[p]));
			txm = dir[p][0] && (|(x.tx_port_mask & pmask[p]) || |(x.cpu_dest_mask & cpu[p]));
			hit = (rxm || txm) && (vl[p] != 2'h1 || x.vlan_entry_copy_flag)
				&& (vl[p] != 2'h2 || x.vid == vid[p]) && (!sta[p][1] || x.src_copy_flag)
				&& (!sta[p][0] || x.dst_copy_flag || (x.flooded && flood));
			if (x.rule_hit && x.rule_probe == p) begin
				hit = dir[p] != 2'h0;
				rxm = dir[p][1];
			end
			if (hit) begin
				c.copy = 1'b1;
				c.probe = 2'(p);
				c.dest = dest[p];
				c.is_rx = rxm;
			end
		end
		c.rewrite_port = c.is_rx ? c.dest : txp;
		c.add_qtag = c.is_rx ? rxtag : txtag;
		return c;
	endfunction : expect_copy

	task send(input mrp_frame_s x, input int bound, output logic got);
		int n;
		in_valid_i <= 1'b1;
		in_frame_i <= x;
		got = 1'b0;
		for (n = 0; n < bound && !got; n++) begin
			@(posedge sys_clk_i);
			got = (in_ready_o === 1'b1);
		end
		if (got) begin
			fq.push_back(x);
			cq.push_back(expect_copy(x));
			taken++;
			copies += cq[$].copy;
		end
	endtask : send

	task drain;
		in_valid_i <= 1'b0;
		for (int n = 0; n < 300 && fq.size() > 0; n++) @(posedge sys_clk_i);
		check(fq.size(), 0);
	endtask : drain

	// Every output word is compared with the oldest expectation.
	always @(posedge sys_clk_i) begin
		if (rst_n_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
			if (fq.size() == 0) begin
				check(1, 0);
			end else begin
				e = cq.pop_front();
				check(out_frame_o, fq.pop_front());
				if (e.copy) check(out_copy_o, e);
				else check(out_copy_o.copy, 1'b0);
			end
		end
	end

	// Watchdog against a hung handshake.
	initial begin
		#200_000;
		miscompares++;
		complete_run();
	end

	// Main sequence: reset, configure, stream, fill the buffer, read counters.
	initial begin
		{wr_i, rd_i, in_valid_i, hold, addr_i, wr_data_i} = '0;
		in_frame_i = '0;
		rst_n_i = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(REG_CTRL, d);
		check(d, 32'h0000_0000);
		for (int r = 0; r < 24; r++) begin
			{flood, rxtag, txtag, txp} = 7'($random(seed));
			for (int p = 0; p < 3; p++) begin
				dir[p] = 2'($random(seed));
				vl[p] = 2'(($random(seed) & 3) % 3);
				{sta[p], cpu[p], phys[p], vid[p], pmask[p], rxcv[p], dest[p]} = 37'({$random(seed), $random(seed)});
			end
			if (r == 0) begin
				{dir[0], dir[2], dir[1], pmask[1], vl[1], vid[1]} = {4'h0, 2'h2, 12'h008, 2'h2, 12'h003};
				{dest[1], sta[1], phys[1], rxcv[1]} = {4'hB, 2'h0, 1'b1, 4'h0};
			end
			hold <= (r == 5);
			wr(REG_CTRL, {20'h0_0000, txp, 5'h00, txtag, rxtag, flood});
			for (int p = 0; p < 3; p++) begin
				wr(AW'(p << PRB_LSB) | AW'(REG_CFG), cfg_word(p));
				wr(AW'(p << PRB_LSB) | AW'(REG_PORT), DW'(pmask[p]));
				wr(AW'(p << PRB_LSB) | AW'(REG_CPU), DW'(cpu[p]));
				wr(AW'(p << PRB_LSB) | AW'(REG_RXCV), DW'(rxcv[p]));
				wr(AW'(p << PRB_LSB) | AW'(REG_DEST), DW'(dest[p]));
			end
			rd(AW'((r % 3) << PRB_LSB), d);
			check(d, cfg_word(r % 3));
			t0 = taken;
			for (int i = 0; i < (r == 5 ? 40 : 20); i++) begin
				f = rnd_frame();
				if (r == 0) begin
					{f.rx_phys_port, f.rx_masq_port, f.rule_hit} = {4'h3, 4'h5, 1'b0};
					f.vid = i[0] ? 12'h003 : 12'h004;
				end
				send(f, (r == 5) ? 4 : 50, ok);
				if (!ok) break;
			end
			if (r == 5) check(taken - t0 >= 16 && !ok, 1);
			hold <= 1'b0;
			drain();
		end
		rd(REG_FRAMES, d);
		check(d, DW'(taken & 32'h0000_FFFF));
		rd(REG_COPIES, d);
		check(d, DW'(copies & 32'h0000_FFFF));
		rd(8'h7C, d);
		check(d, 32'h0000_0000);
		complete_run();
	end
endmodule : test_switch_traffic_mirror_probes
